/* dv/vsag_top_asserts.sv */
// checker that watches the register bank ports
`timescale 1ns/10ps
module vsag_chk (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, active low
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp, // read response
	input wire logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	input wire logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire vsag_pkg::vsag_field_cfg_t field_cfg, // field settings
	input wire vsag_pkg::vsag_conv_cfg_t conv_cfg // converter settings
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	// read request taken this cycle
	logic ar_go;
	assign ar_go = s_axi_arvalid && s_axi_arready;
	a_read_timing: assert property (ar_go |-> ##1 !s_axi_rvalid ##1 s_axi_rvalid)
		else $error("read answer not two cycles after request");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	a_test_fixed: assert property (
		ar_go && s_axi_araddr == 8'h54 |-> ##2 s_axi_rdata == 32'h00000001)
		else $error("test register read wrong");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_unmapped_err: assert property (ar_go && s_axi_araddr == 8'h58 |->
		##2 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_ref_drive: assert property (
		conv_cfg.converter_reference_output_en == !conv_cfg.gain_control_disable)
		else $error("reference drive wrong");
	a_reset_vals: assert property ($rose(aresetn) |->
		conv_cfg.agc_gate_offset == 8'h68 && conv_cfg.burst_gate_offset == 8'h5D
		&& conv_cfg.chroma_conv_sleep && field_cfg.chroma_comb_en)
		else $error("reset settings wrong");
endmodule
bind vsag_top vsag_chk u_chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.field_cfg(field_cfg),
	.conv_cfg(conv_cfg)
);

/* dv/vsag_top_tb.sv */
// testbench for the scaling and converter register bank
`timescale 1ns/10ps
module vsag_top_tb;
	logic aclk = 0, aresetn = 0, ce = 1, odd_field = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	vsag_pkg::vsag_field_cfg_t field_cfg;
	vsag_pkg::vsag_conv_cfg_t conv_cfg;
	int bad_count = 0, comparisons = 0;
	logic [7:0] adr [8] = '{8'h4C, 8'h50, 8'h54, 8'h60, 8'h64, 8'h68, 8'hCC, 8'hD0};
	logic [7:0] rst [8] = '{8'h60, 8'h00, 8'h01, 8'h68, 8'h5D, 8'h82, 8'h60, 8'h00};
	logic [7:0] nv [8];
	logic [12:0] er;
	vsag_top dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.odd_field(odd_field),
		.field_cfg(field_cfg),
		.conv_cfg(conv_cfg)
	);
	// clock generator
	always #25 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t ns: %h, expected %h", $time, s, e);
		end
	endtask
	// one axi4-lite write (w=1) or read, answer left in q and r
	task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
		logic sa, sw, sb, sr, sq;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		forever begin
			@(negedge aclk);
			if (!(s_axi_awvalid | s_axi_wvalid | s_axi_bready | s_axi_arvalid
				| s_axi_rready)) break;
			sa = s_axi_awready & s_axi_awvalid;
			sw = s_axi_wready & s_axi_wvalid;
			sb = s_axi_bvalid & s_axi_bready;
			sr = s_axi_arready & s_axi_arvalid;
			sq = s_axi_rvalid & s_axi_rready;
			if (sb) r = s_axi_bresp;
			if (sq) q = s_axi_rdata;
			if (sq) r = s_axi_rresp;
			@(posedge aclk);
			if (sa) s_axi_awvalid <= 0;
			if (sw) s_axi_wvalid <= 0;
			if (sb) s_axi_bready <= 0;
			if (sr) s_axi_arvalid <= 0;
			if (sq) s_axi_rready <= 0;
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		#200000;
		bad_count++;
		stop_test;
	end
	// main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		@(negedge aclk);
		chk(32'(field_cfg), 32'h00006000);
		chk(32'(conv_cfg),
			32'({16'h685D, 7'b0010010}));
		for (int i = 0; i < 8; i++) begin
			bus(0, adr[i], 32'h0);
			chk({30'h0, r}, 32'h0);
			chk(q, {24'h0, rst[i]});
		end
		er = 13'((32'h10000 - (2 - 1) * 512) & 32'h1FFF);
		nv = '{{3'b100, er[12:8]}, er[7:0], 8'h01, 8'h8A, 8'h7B,
			8'h9D, 8'h35, 8'h5A};
		for (int i = 0; i < 8; i++) begin
			bus(1, adr[i], {24'hA5C3E1, nv[i]});
			chk({30'h0, r}, 32'h0);
		end
		for (int i = 0; i < 8; i++) begin
			bus(0, adr[i], 32'h0);
			chk(q, {24'h0, nv[i]});
		end
		@(negedge aclk);
		chk(32'(field_cfg), {16'h0, nv[0], nv[1]});
		@(posedge aclk);
		odd_field <= 1;
		repeat (2) @(negedge aclk);
		chk(32'(field_cfg), 32'h0000355A);
		chk(32'(conv_cfg),
			32'({16'h8A7B, 7'b0101101}));
		bus(1, 8'h68, 32'h00000086);
		repeat (2) @(negedge aclk);
		chk(32'(conv_cfg),
			32'({16'h8A7B, 7'b0010110}));
		// lane 0 strobe low: write answered but dropped
		@(posedge aclk);
		s_axi_wstrb <= 4'hE;
		bus(1, 8'h50, 32'h00000077);
		chk({30'h0, r}, 32'h0);
		@(posedge aclk);
		s_axi_wstrb <= 4'hF;
		bus(0, 8'h50, 32'h0);
		chk(q, {24'h0, nv[1]});
		// clock enable low freezes the outputs
		@(posedge aclk);
		ce <= 0;
		odd_field <= 0;
		repeat (3) @(negedge aclk);
		chk(32'(field_cfg), 32'h0000355A);
		@(posedge aclk);
		ce <= 1;
		repeat (2) @(negedge aclk);
		chk(32'(field_cfg), {16'h0, nv[0], nv[1]});
		bus(1, 8'h58, 32'h12345678);
		chk({30'h0, r}, 32'h2);
		bus(0, 8'h58, 32'h0);
		chk({30'h0, r}, 32'h2);
		chk(q, 32'h0);
		stop_test;
	end
endmodule

/* hw/vsag_pkg.sv */
// package of constants and carrier types for the scaling/agc register bank
// Contract
// - luma comb bit selects lowpass-only filtering
// - chroma comb bit inserts line store averaging
// - interlace flag selects interlaced vertical scaling
// - ratio is upper five bits plus lower byte
// - separate even and odd scaling register copies
// - test register always reads 0x01
// - agc gate delay positions back-porch gate
// - burst gate delay positions burst gate
// - sync threshold bit selects detector threshold
// - clock sleep powers down decoder clock
// - luma converter sleep bit
// - chroma converter sleep bit, reset asleep
// - adaptive gain enable raises reference on overflow
package vsag_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_E_HI = 8'h4C;
	localparam logic [7:0] OFF_E_LO = 8'h50;
	localparam logic [7:0] OFF_TEST = 8'h54;
	localparam logic [7:0] OFF_AGC = 8'h60;
	localparam logic [7:0] OFF_BURST = 8'h64;
	localparam logic [7:0] OFF_CONV = 8'h68;
	localparam logic [7:0] OFF_O_HI = 8'hCC;
	localparam logic [7:0] OFF_O_LO = 8'hD0;
	localparam logic [7:0] RST_HI = 8'h60;
	localparam logic [7:0] RST_LO = 8'h00;
	localparam logic [7:0] RST_AGC = 8'h68;
	localparam logic [7:0] RST_BURST = 8'h5D;
	localparam logic [7:0] RST_CONV = 8'h82;
	localparam logic [7:0] TEST_VAL = 8'h01;
	// upper scaling register fields
	localparam int BIT_LUMA_COMB_MODE = 7;
	localparam int BIT_CCOMB = 6;
	localparam int BIT_INTL = 5;
	// converter interface fields
	localparam int BIT_SYNC = 5;
	localparam int BIT_AGCDIS = 4;
	localparam int BIT_CLKSLP = 3;
	localparam int BIT_YSLP = 2;
	localparam int BIT_CSLP = 1;
	localparam int BIT_ADAPT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// per-field scaling and comb controls
	typedef struct packed {
		logic luma_comb_mode;
		logic chroma_comb_en;
		logic interlace;
		logic [12:0] vertical_ratio;
	} vsag_field_cfg_t;

	// converter and gate controls
	typedef struct packed {
		logic [7:0] agc_gate_offset;
		logic [7:0] burst_gate_offset;
		logic sync_low_threshold;
		logic gain_control_disable;
		logic converter_reference_output_en;
		logic decoder_clock_sleep;
		logic luma_conv_sleep;
		logic chroma_conv_sleep;
		logic adaptive_gain_enable;
	} vsag_conv_cfg_t;
endpackage

/* hw/vsag_regfile.sv */
// small register store: eight-bit words, registered read data
`timescale 1ns/10ps
module vsag_regfile (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, active low
	input wire logic ce, // clock enable
	input wire logic we, // write strobe
	input wire logic [2:0] waddr, // write slot
	input wire logic [7:0] wdata, // write data
	input wire logic [2:0] raddr, // read slot
	output logic [7:0] rdata, // registered read data
	output logic [63:0] flat // all slots, slot i at [8i+7:8i]
);
	localparam logic [63:0] RST_ALL = {vsag_pkg::RST_LO,
		vsag_pkg::RST_HI, vsag_pkg::RST_CONV, vsag_pkg::RST_BURST,
		vsag_pkg::RST_AGC, vsag_pkg::TEST_VAL, vsag_pkg::RST_LO,
		vsag_pkg::RST_HI};

	typedef struct packed {
		logic [63:0] mem;
		logic [7:0] rd;
	} vsag_rf_state_t;

	vsag_rf_state_t s_q;
	vsag_rf_state_t s_d;

	// write and read port
	always_comb begin
		s_d = s_q;
		if (we) begin
			s_d.mem[waddr*8 +: 8] = wdata;
		end
		s_d.rd = s_q.mem[raddr*8 +: 8];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= {RST_ALL, 8'h00};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rd;
	assign flat = s_q.mem;
endmodule

/* hw/vsag_top.sv */
// axi4-lite register bank for vertical scaling, comb and converter control
`timescale 1ns/10ps
module vsag_top (
	input wire logic aclk, // 20 MHz clock
	input wire logic aresetn, // sync reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic odd_field, // current field parity, 1 = odd
	output vsag_pkg::vsag_field_cfg_t field_cfg, // active field settings
	output vsag_pkg::vsag_conv_cfg_t conv_cfg // converter and gate settings
);
	typedef enum logic [1:0] {ST_IDLE, ST_RWAIT, ST_RDATA} vsag_rd_t;

	typedef struct packed {
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		vsag_rd_t rst;
		logic [7:0] ar_addr;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		vsag_pkg::vsag_field_cfg_t fcfg;
		vsag_pkg::vsag_conv_cfg_t ccfg;
	} vsag_state_t;

	vsag_state_t s_q;
	vsag_state_t s_d;
	logic rf_we;
	logic [2:0] rf_waddr;
	logic [2:0] rf_raddr;
	logic [7:0] rf_rdata;
	logic [63:0] rf_flat;

	////////////////////////////////////////////////////////////////////////
	// address decode: slot number, and whether the offset is mapped
	function automatic logic [3:0] vsag_decode(input logic [7:0] a);
		unique case (a)
			vsag_pkg::OFF_E_HI: vsag_decode = 4'h8;
			vsag_pkg::OFF_E_LO: vsag_decode = 4'h9;
			vsag_pkg::OFF_TEST: vsag_decode = 4'hA;
			vsag_pkg::OFF_AGC: vsag_decode = 4'hB;
			vsag_pkg::OFF_BURST: vsag_decode = 4'hC;
			vsag_pkg::OFF_CONV: vsag_decode = 4'hD;
			vsag_pkg::OFF_O_HI: vsag_decode = 4'hE;
			vsag_pkg::OFF_O_LO: vsag_decode = 4'hF;
			default: vsag_decode = 4'h0;
		endcase
	endfunction

	// slot i of the store
	function automatic logic [7:0] vsag_slot(input logic [63:0] f,
			input int i);
		vsag_slot = f[i*8 +: 8];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register store
	vsag_regfile u_rf (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.we(rf_we),
		.waddr(rf_waddr),
		.wdata(s_q.w_data),
		.raddr(rf_raddr),
		.rdata(rf_rdata),
		.flat(rf_flat)
	);

	// write commits once both halves are held and no response pends;
	// read slot follows the bus address while idle, so the store's
	// registered read data is ready one cycle after the request
	always_comb begin
		logic [3:0] dec;
		logic [3:0] rdec;
		dec = vsag_decode(s_q.aw_addr);
		rdec = (s_q.rst == ST_IDLE) ? vsag_decode(s_axi_araddr) :
			vsag_decode(s_q.ar_addr);
		rf_waddr = dec[2:0];
		// test slot is never written: it reads fixed
		rf_we = s_q.aw_have && s_q.w_have && !s_q.bvalid && dec[3] &&
			s_q.w_lane0 && (dec[2:0] != 3'h2);
		rf_raddr = rdec[2:0];
	end

	////////////////////////////////////////////////////////////////////////
	// bus handshakes and derived controls
	always_comb begin
		logic [7:0] hi;
		logic [7:0] lo;
		logic [7:0] cv;
		hi = 8'h00;
		lo = 8'h00;
		cv = vsag_slot(rf_flat, 5);
		s_d = s_q;
		// write address and data captured independently
		if (!s_q.aw_have && s_axi_awvalid) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (!s_q.w_have && s_axi_wvalid) begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata[7:0];
			s_d.w_lane0 = s_axi_wstrb[0];
		end
		// response once both held
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
			s_d.bvalid = 1'b1;
			s_d.bresp = vsag_decode(s_q.aw_addr) >= 4'h8 ?
				vsag_pkg::RESP_OKAY : vsag_pkg::RESP_SLVERR;
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// read: address, one cycle for registered store, then data
		unique case (s_q.rst)
			ST_IDLE: begin
				if (s_axi_arvalid) begin
					s_d.ar_addr = s_axi_araddr;
					s_d.rst = ST_RWAIT;
				end
			end
			ST_RWAIT: begin
				s_d.rst = ST_RDATA;
				s_d.rvalid = 1'b1;
				if (vsag_decode(s_q.ar_addr) >= 4'h8) begin
					s_d.rdata = {24'h000000, rf_rdata};
					s_d.rresp = vsag_pkg::RESP_OKAY;
				end else begin
					s_d.rdata = 32'h00000000;
					s_d.rresp = vsag_pkg::RESP_SLVERR;
				end
			end
			ST_RDATA: begin
				if (s_axi_rready) begin
					s_d.rvalid = 1'b0;
					s_d.rst = ST_IDLE;
				end
			end
		endcase
		// active field set chosen by parity
		if (odd_field) begin
			hi = vsag_slot(rf_flat, 6);
			lo = vsag_slot(rf_flat, 7);
		end else begin
			hi = vsag_slot(rf_flat, 0);
			lo = vsag_slot(rf_flat, 1);
		end
		s_d.fcfg.luma_comb_mode = hi[vsag_pkg::BIT_LUMA_COMB_MODE];
		s_d.fcfg.chroma_comb_en = hi[vsag_pkg::BIT_CCOMB];
		s_d.fcfg.interlace = hi[vsag_pkg::BIT_INTL];
		s_d.fcfg.vertical_ratio = {hi[4:0], lo};
		// gate offsets and converter controls
		s_d.ccfg.agc_gate_offset = vsag_slot(rf_flat, 3);
		s_d.ccfg.burst_gate_offset = vsag_slot(rf_flat, 4);
		s_d.ccfg.sync_low_threshold = cv[vsag_pkg::BIT_SYNC];
		s_d.ccfg.gain_control_disable = cv[vsag_pkg::BIT_AGCDIS];
		// reference driven only while gain control runs
		s_d.ccfg.converter_reference_output_en =
			!cv[vsag_pkg::BIT_AGCDIS];
		s_d.ccfg.decoder_clock_sleep = cv[vsag_pkg::BIT_CLKSLP];
		s_d.ccfg.luma_conv_sleep = cv[vsag_pkg::BIT_YSLP];
		s_d.ccfg.chroma_conv_sleep = cv[vsag_pkg::BIT_CSLP];
		s_d.ccfg.adaptive_gain_enable = cv[vsag_pkg::BIT_ADAPT];
	end

	// state register, reset values match the store's reset contents
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.rst <= ST_IDLE;
			s_q.fcfg <= {1'b0, 1'b1, 1'b1, 13'h0000};
			s_q.ccfg <= {vsag_pkg::RST_AGC, vsag_pkg::RST_BURST,
				7'b0010010};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	assign s_axi_awready = !s_q.aw_have;
	assign s_axi_wready = !s_q.w_have;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = (s_q.rst == ST_IDLE);
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign field_cfg = s_q.fcfg;
	assign conv_cfg = s_q.ccfg;
endmodule
